// ---- smr_supply_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module smr_supply_monitor
  import smr_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire smr_bus_req_t bus_req,
  input  wire smr_cause_t   cause,
  output logic [7:0]        bus_rdata,
  output logic              int_reset_req,
  output logic              detect_enable,
  output logic [3:0]        level_code,
  output logic              supply_low_irq,
  output logic              supply_low_irq_pulse
);
  logic       en_q, en_d;
  logic       md_q, md_d;
  logic       flag_q, flag_d;
  logic [3:0] lvl_q, lvl_d;
  logic       wdt_flag_q, wdt_flag_d;
  logic       lv_flag_q, lv_flag_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rst_q, rst_d;
  logic       irq_q, irq_d;
  logic       lvd_rst;
  logic       hard_clr;
  logic       wr_ctl, wr_lvl, rd_cause;
  logic [7:0] ctl_view, cause_view;

  // Decode and register views
  always_comb begin
    wr_ctl   = bus_req.wr & (bus_req.addr == ADDR_LV_CONTROL);
    wr_lvl   = bus_req.wr & (bus_req.addr == ADDR_LEVEL_SEL);
    rd_cause = bus_req.rd & (bus_req.addr == ADDR_RESET_CAUSE);
    lvd_rst  = en_q & md_q & flag_q;
    hard_clr = cause.poc_low | cause.ext_rst;
    ctl_view = 8'h00;
    ctl_view[BIT_DETECT_EN]  = en_q;
    ctl_view[BIT_ACTION_SEL] = md_q;
    ctl_view[BIT_LOW_FLAG]   = flag_q;
    cause_view = 8'h00;
    cause_view[BIT_WDT_CAUSE] = wdt_flag_q;
    cause_view[BIT_LV_CAUSE]  = lv_flag_q;
  end

  // Control and level registers; detector reset holds them
  always_comb begin
    en_d  = en_q;
    md_d  = md_q;
    lvl_d = lvl_q;
    if (hard_clr || cause.wdt_rst) begin
      en_d  = RST_LV_CONTROL[BIT_DETECT_EN];
      md_d  = RST_LV_CONTROL[BIT_ACTION_SEL];
      lvl_d = RST_LEVEL_CODE;
    end else if (!lvd_rst) begin
      if (wr_ctl) begin
        en_d = bus_req.wdata[BIT_DETECT_EN];
        md_d = bus_req.wdata[BIT_ACTION_SEL];
      end
      if (wr_lvl) begin
        lvl_d = bus_req.wdata[3:0];
      end
    end
    flag_d = en_d & cause.lvd_low;
  end

  // Reset-cause flags; a set wins over a read clear
  always_comb begin
    wdt_flag_d = wdt_flag_q;
    lv_flag_d  = lv_flag_q;
    if (hard_clr) begin
      wdt_flag_d = 1'b0;
      lv_flag_d  = 1'b0;
    end else begin
      if (rd_cause) begin
        wdt_flag_d = 1'b0;
        lv_flag_d  = 1'b0;
      end
      if (cause.wdt_rst) begin
        wdt_flag_d = 1'b1;
      end
      if (lvd_rst) begin
        lv_flag_d = 1'b1;
      end
    end
  end

  // Read data, reset request and interrupt level
  always_comb begin
    rdata_d = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_LV_CONTROL:  rdata_d = ctl_view;
        ADDR_LEVEL_SEL:   rdata_d = {4'h0, lvl_q};
        ADDR_RESET_CAUSE: rdata_d = cause_view;
        default:          rdata_d = 8'h00;
      endcase
    end
    rst_d = cause.poc_low | lvd_rst;
    irq_d = en_q & ~md_q & flag_q;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en_q       <= 1'b0;
      md_q       <= 1'b0;
      flag_q     <= 1'b0;
      lvl_q      <= RST_LEVEL_CODE;
      wdt_flag_q <= 1'b0;
      lv_flag_q  <= 1'b0;
      rdata_q    <= 8'h00;
      rst_q      <= 1'b1;
      irq_q      <= 1'b0;
    end else begin
      en_q       <= en_d;
      md_q       <= md_d;
      flag_q     <= flag_d;
      lvl_q      <= lvl_d;
      wdt_flag_q <= wdt_flag_d;
      lv_flag_q  <= lv_flag_d;
      rdata_q    <= rdata_d;
      rst_q      <= rst_d;
      irq_q      <= irq_d;
    end
  end

  // Edge pulse for interrupt mode
  smr_rise_pulse u_irq_edge (
    .mclk   (mclk),
    .arst_n (arst_n),
    .level  (irq_q),
    .pulse  (supply_low_irq_pulse)
  );

  // Output drive
  assign bus_rdata      = rdata_q;
  assign int_reset_req  = rst_q;
  assign detect_enable  = en_q;
  assign level_code     = lvl_q;
  assign supply_low_irq = irq_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_WDT_SET: assert property (
    cause.wdt_rst && !hard_clr |=> wdt_flag_q)
    else $error("watchdog cause flag not set");
  AST_EXT_CLR: assert property (
    cause.ext_rst |=> !wdt_flag_q && !lv_flag_q && !en_q && lvl_q == 4'h0)
    else $error("pin reset did not clear state");
  AST_LVD_SET: assert property (
    lvd_rst && !hard_clr |=> lv_flag_q)
    else $error("low-voltage cause flag not set");
  AST_POC_CLR: assert property (
    cause.poc_low |=> cause_view == 8'h00 ##0 rst_q)
    else $error("power-on reset did not clear causes");
  AST_KEEP_OTHER: assert property (
    cause.wdt_rst && !hard_clr && !rd_cause && lv_flag_q |=> lv_flag_q)
    else $error("watchdog reset lost low-voltage flag");
  AST_CTL_HOLD: assert property (
    lvd_rst && !hard_clr && !cause.wdt_rst |=> $stable(en_q) && $stable(md_q)
      && $stable(lvl_q))
    else $error("detector reset changed control");
  AST_FLAG_OFF: assert property (
    !en_q |-> !flag_q)
    else $error("low flag set while disabled");
  AST_IRQ: assert property (
    en_q && !md_q && flag_q
      |=> irq_q ##1 (supply_low_irq_pulse || $past(irq_q, 2)))
    else $error("interrupt request missing");
  AST_PULSE: assert property (
    supply_low_irq_pulse |=> !supply_low_irq_pulse)
    else $error("interrupt pulse longer than one cycle");
  AST_RD_CLR: assert property (
    rd_cause && !hard_clr && !cause.wdt_rst && !lvd_rst
      |=> cause_view == 8'h00)
    else $error("read did not clear causes");
  AST_LVL_WR: assert property (
    wr_lvl && !hard_clr && !cause.wdt_rst && !lvd_rst
      |=> lvl_q == $past(bus_req.wdata[3:0]))
    else $error("level write not stored");

  // Cause flags and reset request
  AST_KEEP_WDT: assert property (
    lvd_rst && !hard_clr && !rd_cause && wdt_flag_q |=> wdt_flag_q)
    else $error("detector reset lost watchdog flag");
  AST_POC_REQ: assert property (
    cause.poc_low |=> int_reset_req)
    else $error("power-on reset request missing");
  AST_REQ_FREE: assert property (
    !cause.poc_low && !lvd_rst |=> !int_reset_req)
    else $error("reset request not released");

  // Control register and interrupt checks
  AST_SOFT_CLR: assert property (
    cause.poc_low || cause.wdt_rst
      |=> !en_q && !md_q && lvl_q == RST_LEVEL_CODE)
    else $error("control not cleared by reset");
  AST_CTL_WR: assert property (
    wr_ctl && !hard_clr && !cause.wdt_rst && !lvd_rst
      |=> en_q == $past(bus_req.wdata[BIT_DETECT_EN])
      && md_q == $past(bus_req.wdata[BIT_ACTION_SEL]))
    else $error("control write not stored");
  AST_FLAG_SET: assert property (
    en_q && cause.lvd_low && !hard_clr && !cause.wdt_rst && !wr_ctl
      |=> flag_q)
    else $error("low flag not set");
  AST_RST_MODE: assert property (
    md_q |=> !supply_low_irq)
    else $error("interrupt raised in reset mode");
  AST_OFF_IRQ: assert property (
    !en_q |=> !supply_low_irq)
    else $error("interrupt raised while disabled");

  // Main scenarios
  COV_POC_RESET: cover property (cause.poc_low ##1 int_reset_req);
  COV_LVD_RESET: cover property (lvd_rst ##1 rst_q);
  COV_WDT_CAUSE: cover property (cause.wdt_rst ##1 rd_cause);
  COV_IRQ_PULSE: cover property (supply_low_irq_pulse);
endmodule // smr_supply_monitor
`default_nettype wire

// ---- smr_pkg.sv ----
`default_nettype none
package smr_pkg;
  localparam logic [15:0] ADDR_LV_CONTROL  = 16'hFF50;
  localparam logic [15:0] ADDR_LEVEL_SEL   = 16'hFF51;
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'hFF54;
  localparam int          BIT_DETECT_EN    = 7;
  localparam int          BIT_ACTION_SEL   = 1;
  localparam int          BIT_LOW_FLAG     = 0;
  localparam int          BIT_LV_CAUSE     = 0;
  localparam int          BIT_WDT_CAUSE    = 4;
  localparam logic [7:0]  RST_LV_CONTROL   = 8'h00;
  localparam logic [3:0]  RST_LEVEL_CODE   = 4'h0;
  localparam logic [3:0]  LEVEL_CODE_MAX   = 4'h9;

  // Processor memory-bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } smr_bus_req_t;

  // Supervisor and reset-source inputs
  typedef struct packed {
    logic poc_low;
    logic ext_rst;
    logic wdt_rst;
    logic lvd_low;
  } smr_cause_t;
endpackage
`default_nettype wire

// ---- smr_rise_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
module smr_rise_pulse
  import smr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic level,
  output logic      pulse
);
  logic prev_q;
  logic prev_d;
  logic pulse_q;
  logic pulse_d;

  // One pulse on each low-to-high change
  always_comb begin
    prev_d  = level;
    pulse_d = level & ~prev_q;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;
endmodule // smr_rise_pulse
`default_nettype wire

// ---- smr_supply_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module smr_supply_model
  import smr_pkg::*;
(
  input  wire logic [8:0] supply_cv,
  input  wire logic       detect_enable,
  input  wire logic [3:0] level_code,
  output logic            poc_low,
  output logic            lvd_low
);
  // Thresholds in units of 10 mV, code 0 highest down to code 9 lowest
  localparam logic [8:0] THR [10] = '{9'h1AE, 9'h19A, 9'h186, 9'h172,
    9'h15E, 9'h14A, 9'h136, 9'h11D, 9'h104, 9'h0EB};
  logic [8:0] thr;

  // Comparators: detector runs only while enabled
  always_comb begin
    thr     = (level_code <= LEVEL_CODE_MAX) ? THR[level_code] : 9'h000;
    poc_low = supply_cv < 9'h0D2;
    lvd_low = detect_enable && (supply_cv < thr);
  end
endmodule // smr_supply_model
`default_nettype wire

// ---- supply_monitor_reset_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_reset_flags_tb
  import smr_pkg::*;
;
  logic         mclk, arst_n, wdt, ext, pend, poc_low, lvd_low;
  logic         int_reset_req, detect_enable, irq, irq_pulse;
  smr_bus_req_t bus_req;
  smr_cause_t   cause;
  logic [7:0]   bus_rdata;
  logic [8:0]   supply_cv;
  logic [3:0]   level_code, code;
  logic [31:0]  rng;
  logic [7:0]   exp_q [$];
  int           n_errors, checks_done, n_pulse, n0;
  // Detector settle time after enabling: 0.2 ms of 50 ns cycles
  localparam int SETTLE_CYC = 4000;

  assign cause = '{poc_low: poc_low, ext_rst: ext, wdt_rst: wdt,
                   lvd_low: lvd_low};

  smr_supply_monitor dut (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req),
    .cause(cause), .bus_rdata(bus_rdata), .int_reset_req(int_reset_req),
    .detect_enable(detect_enable), .level_code(level_code),
    .supply_low_irq(irq), .supply_low_irq_pulse(irq_pulse));

  smr_supply_model model (.supply_cv(supply_cv),
    .detect_enable(detect_enable), .level_code(level_code),
    .poc_low(poc_low), .lvd_low(lvd_low));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles: raise on one falling edge, drop on the next
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk);
    bus_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge mclk);
    exp_q.push_back(e);
    bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge mclk);
    bus_req.rd = 1'b0;
  endtask

  // One-cycle reset source pulse
  task automatic hit(input logic w, input logic e);
    @(negedge mclk);
    wdt = w;
    ext = e;
    @(negedge mclk);
    wdt = 1'b0;
    ext = 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Read data is due one cycle after the read is taken
  always @(posedge mclk) pend <= bus_req.rd;
  always @(negedge mclk) if (pend === 1'b1) chk(bus_rdata, exp_q.pop_front());
  // Pulses are counted away from the edge that launches them
  always @(negedge mclk) if (irq_pulse === 1'b1) n_pulse++;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    // Two settle waits plus about 120 bus cycles, with ample margin
    #1000000;
    n_errors++;
    end_sim();
  end

  initial begin
    arst_n = 1'b0; bus_req = '0; wdt = 1'b0; ext = 1'b0; supply_cv = 9'h1F4;
    rng = 32'h30FF; n_errors = 0; checks_done = 0; n_pulse = 0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    rd(ADDR_LV_CONTROL, RST_LV_CONTROL);
    rd(ADDR_LEVEL_SEL, 8'h00);
    rd(ADDR_RESET_CAUSE, 8'h00);
    rd(16'hFF52, 8'h00);
    $display("test reset values done");
    // Every level code from a random start, detection off while writing
    rng = xs(rng);
    for (int i = 0; i < 10; i++) begin
      code = 4'((rng[7:0] + i) % 10);
      wr(ADDR_LEVEL_SEL, {4'h0, code});
      rd(ADDR_LEVEL_SEL, {4'h0, code});
      chk({4'h0, level_code}, {4'h0, code});
    end
    $display("test level codes done");
    // Interrupt mode: bit 0 not writable, flag drives the request
    wr(ADDR_LEVEL_SEL, 8'h03);
    wr(ADDR_LV_CONTROL, 8'h81);
    chk({7'h0, detect_enable}, 8'h01);
    repeat (SETTLE_CYC) @(negedge mclk);
    rd(ADDR_LV_CONTROL, 8'h80);
    n0 = n_pulse;
    supply_cv = 9'h15E;
    repeat (6) @(negedge mclk);
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_LV_CONTROL, 8'h81);
    chk(8'(n_pulse - n0), 8'h01);
    supply_cv = 9'h1F4;
    rd(ADDR_LV_CONTROL, 8'h80);
    wr(ADDR_LV_CONTROL, 8'h00);
    rd(ADDR_LV_CONTROL, 8'h00);
    chk({7'h0, detect_enable}, 8'h00);
    $display("test interrupt mode done");
    // Reset mode between two watchdog resets, writes refused meanwhile
    hit(1'b1, 1'b0);
    wr(ADDR_LEVEL_SEL, 8'h03);
    wr(ADDR_LV_CONTROL, 8'h80);
    repeat (SETTLE_CYC) @(negedge mclk);
    rd(ADDR_LV_CONTROL, 8'h80);
    wr(ADDR_LV_CONTROL, 8'h82);
    supply_cv = 9'h15E;
    repeat (4) @(negedge mclk);
    chk({7'h0, int_reset_req}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_LV_CONTROL, 8'h00);
    supply_cv = 9'h1F4;
    repeat (4) @(negedge mclk);
    chk({7'h0, int_reset_req}, 8'h00);
    rd(ADDR_LV_CONTROL, 8'h82);
    rd(ADDR_LEVEL_SEL, 8'h03);
    hit(1'b1, 1'b0);
    rd(ADDR_RESET_CAUSE, 8'h11);
    rd(ADDR_RESET_CAUSE, 8'h00);
    rd(ADDR_LV_CONTROL, 8'h00);
    $display("test detector reset done");
    // Power-on dip and reset pin both clear the causes
    hit(1'b1, 1'b0);
    supply_cv = 9'h0C8;
    repeat (3) @(negedge mclk);
    chk({7'h0, int_reset_req}, 8'h01);
    supply_cv = 9'h1F4;
    rd(ADDR_RESET_CAUSE, 8'h00);
    hit(1'b1, 1'b0);
    hit(1'b0, 1'b1);
    rd(ADDR_RESET_CAUSE, 8'h00);
    repeat (2) @(negedge mclk);
    $display("test power and pin resets done");
    end_sim();
  end
endmodule // supply_monitor_reset_flags_tb
`default_nettype wire
